// ---- hw/iso_link_regs_pkg.sv ----
// Constants and carrier types for the isochronous interrupt and link control register bank
`default_nettype none
package iso_link_regs_pkg;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ----------------------------------------
	// Byte offsets (set / clear pairs, and the single fairness offset)
	// ----------------------------------------
	localparam logic [11:0] OFS_XMIT_MASK_SET = 12'h098;
	localparam logic [11:0] OFS_XMIT_MASK_CLR = 12'h09C;
	localparam logic [11:0] OFS_RCV_EVENT_SET = 12'h0A0;
	localparam logic [11:0] OFS_RCV_EVENT_CLR = 12'h0A4;
	localparam logic [11:0] OFS_RCV_MASK_SET = 12'h0A8;
	localparam logic [11:0] OFS_RCV_MASK_CLR = 12'h0AC;
	localparam logic [11:0] OFS_FAIRNESS = 12'h0DC;
	localparam logic [11:0] OFS_LINK_SET = 12'h0E0;
	localparam logic [11:0] OFS_LINK_CLR = 12'h0E4;

	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int XMIT_CTX_N = 8;
	localparam int RCV_CTX_N = 4;
	localparam int FAIR_W = 8;
	localparam int LINK_CYCLE_MASTER_BIT = 21;
	localparam int LINK_TIMER_EN_BIT = 20;
	localparam int LINK_RX_PHY_BIT = 10;
	localparam int LINK_SELF_ID_BIT = 9;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] XMIT_MASK_RST = 8'h00;
	localparam logic [3:0] RCV_MASK_RST = 4'h0;
	localparam logic [3:0] RCV_EVENT_RST = 4'h0;
	localparam logic [7:0] FAIR_RST = 8'h00;
	localparam logic [31:0] LINK_RST = 32'h0000_0000;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int CLK_KHZ = 50000;
	localparam int CYC_REF_KHZ = 24576;
	localparam int CYC_OFFSET_MOD = 3072;
	localparam int OVERLONG_MIN_NS = 115000;
	localparam int OVERLONG_MAX_NS = 120000;
	// Least time rounds up to whole cycles
	localparam int OVERLONG_CYCLES = (OVERLONG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic is_phy;
		logic is_self_id;
	} rx_pkt_type;

	typedef struct packed {
		logic phy_to_async_receive;
		logic self_id_accept;
		logic discard;
	} rx_route_type;

endpackage
`default_nettype wire

// ---- hw/cycle_offset_timer.sv ----
// Cycle offset counter driven by a fractional 24.576 MHz enable
`default_nettype none
module cycle_offset_timer
	import iso_link_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic enable,
	output logic [11:0] offset,
	output logic rollover
);

	// ----------------------------------------
	// Reference tick divider
	// ----------------------------------------
	// Phase accumulator gives 24576 ticks per 50000 clocks; jitter of one clock is the price of one clock domain
	localparam logic [16:0] ACC_STEP = 17'(CYC_REF_KHZ);
	localparam logic [16:0] ACC_WRAP = 17'(CLK_KHZ);
	localparam logic [11:0] OFS_LAST = 12'(CYC_OFFSET_MOD - 1);

	logic [16:0] acc_r;
	logic [16:0] acc_sum;
	logic tick;
	logic [11:0] offset_r;
	logic rollover_r;

	assign acc_sum = acc_r + ACC_STEP;
	assign tick = (acc_sum >= ACC_WRAP);

	// Accumulator runs freely
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			acc_r <= 17'h00000;
		end else begin
			acc_r <= tick ? (acc_sum - ACC_WRAP) : acc_sum;
		end
	end

	// ----------------------------------------
	// Offset counter
	// ----------------------------------------
	// Holds while disabled, counts modulo 3072 while enabled
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			offset_r <= 12'h000;
			rollover_r <= 1'b0;
		end else begin
			rollover_r <= 1'b0;
			if (enable && tick) begin
				if (offset_r == OFS_LAST) begin
					offset_r <= 12'h000;
					rollover_r <= 1'b1;
				end else begin
					offset_r <= offset_r + 12'h001;
				end
			end
		end
	end

	assign offset = offset_r;
	assign rollover = rollover_r;

endmodule
`default_nettype wire

// ---- hw/iso_irq_mask_link_control_regs.sv ----
// Isochronous interrupt event and mask registers, fairness limit and link control
//
// Contract
// - Transmit mask bit lets its context interrupt
// - Receive event set on input-last interrupt-always
// - Clear address clears only bits written one
// - Receive event sets only when mask set
// - Receive mask gates context, own set/clear
// - Fairness field limits requests per interval
// - Master clear: accept received cycle starts
// - Master and root: cycle start at rollover
// - Overlong clears master, blocks setting it
// - Timer disabled: offset holds
// - Timer enabled: offset counts reference clocks
// - PHY receive off: discard PHY packets
// - PHY receive on: deliver to request context
// - PHY receive bit ignores self-ID packets
// - Self-ID bit off discards, on accepts
// - Set/clear addresses; either reads current value
// - Overlong past 115 us, within 120 us
// - Offset counts modulo 3072
// - Summary completion is OR of masked events
`default_nettype none
module iso_irq_mask_link_control_regs
	import iso_link_regs_pkg::*;
#(
	parameter int OVERLONG_LIMIT = OVERLONG_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [XMIT_CTX_N-1:0] iso_xmit_ctx_irq,
	input wire logic [RCV_CTX_N-1:0] iso_rcv_input_last_done,
	input wire logic [RCV_CTX_N-1:0] iso_rcv_irq_always,
	output logic [XMIT_CTX_N-1:0] iso_xmit_irq_gated,
	output logic iso_xmit_dma_complete,
	output logic iso_rcv_dma_complete,
	input wire logic fairness_interval_start,
	input wire logic request_pkt_sent,
	output logic request_tx_allowed,
	input wire logic phy_is_root,
	input wire logic cycle_start_tx_begin,
	input wire logic subaction_gap_end,
	input wire logic cycle_too_long_clear,
	output logic cycle_too_long_event,
	output logic accept_rx_cycle_start,
	output logic cycle_start_generate,
	output logic [11:0] cycle_offset,
	input wire rx_pkt_type rx_pkt,
	input wire logic self_id_phase,
	input wire logic async_receive_req_enabled,
	output rx_route_type rx_route
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Full compare, so no alias answers
	logic hit_xmask_set;
	logic hit_xmask_clr;
	logic hit_rev_set;
	logic hit_rev_clr;
	logic hit_rmask_set;
	logic hit_rmask_clr;
	logic hit_fair;
	logic hit_link_set;
	logic hit_link_clr;
	// Any mapped offset
	logic hit_any;

	assign hit_xmask_set = (reg_addr == OFS_XMIT_MASK_SET);
	assign hit_xmask_clr = (reg_addr == OFS_XMIT_MASK_CLR);
	assign hit_rev_set = (reg_addr == OFS_RCV_EVENT_SET);
	assign hit_rev_clr = (reg_addr == OFS_RCV_EVENT_CLR);
	assign hit_rmask_set = (reg_addr == OFS_RCV_MASK_SET);
	assign hit_rmask_clr = (reg_addr == OFS_RCV_MASK_CLR);
	assign hit_fair = (reg_addr == OFS_FAIRNESS);
	assign hit_link_set = (reg_addr == OFS_LINK_SET);
	assign hit_link_clr = (reg_addr == OFS_LINK_CLR);
	assign hit_any = hit_xmask_set | hit_xmask_clr | hit_rev_set | hit_rev_clr | hit_rmask_set
		| hit_rmask_clr | hit_fair | hit_link_set | hit_link_clr;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	// All fields reset to zero
	logic [XMIT_CTX_N-1:0] xmit_mask_r;
	logic [XMIT_CTX_N-1:0] xmit_mask_nxt;
	logic [RCV_CTX_N-1:0] rcv_mask_r;
	logic [RCV_CTX_N-1:0] rcv_mask_nxt;
	logic [RCV_CTX_N-1:0] rcv_event_r;
	logic [RCV_CTX_N-1:0] rcv_event_nxt;
	logic [FAIR_W-1:0] fair_limit_r;
	logic [FAIR_W-1:0] fair_limit_nxt;

	// Link control bits and overlong flag
	logic cycle_master_r;
	logic cycle_master_nxt;
	logic timer_en_r;
	logic timer_en_nxt;
	logic rx_phy_en_r;
	logic rx_phy_en_nxt;
	logic self_id_accept_r;
	logic self_id_accept_nxt;
	logic overlong_r;
	logic overlong_nxt;

	// Writes only touch the implemented low bits; upper data bits are dropped
	logic [XMIT_CTX_N-1:0] wr_x;
	logic [RCV_CTX_N-1:0] wr_r;
	assign wr_x = reg_wdata[XMIT_CTX_N-1:0];
	assign wr_r = reg_wdata[RCV_CTX_N-1:0];

	// Transmit mask: ones at set address set, ones at clear address clear
	assign xmit_mask_nxt = (reg_wr && hit_xmask_set) ? (xmit_mask_r | wr_x)
		: (reg_wr && hit_xmask_clr) ? (xmit_mask_r & ~wr_x) : xmit_mask_r;

	// Receive mask held at its own pair of addresses
	assign rcv_mask_nxt = (reg_wr && hit_rmask_set) ? (rcv_mask_r | wr_r)
		: (reg_wr && hit_rmask_clr) ? (rcv_mask_r & ~wr_r) : rcv_mask_r;

	// ----------------------------------------
	// Receive event bits
	// ----------------------------------------
	// A completion lands only with its mask bit set; a set in the same cycle as a clear wins
	logic [RCV_CTX_N-1:0] rcv_hw_set;
	logic [RCV_CTX_N-1:0] rcv_sw_set;
	logic [RCV_CTX_N-1:0] rcv_sw_clr;
	assign rcv_hw_set = iso_rcv_input_last_done & iso_rcv_irq_always & rcv_mask_r;
	assign rcv_sw_set = (reg_wr && hit_rev_set) ? (wr_r & rcv_mask_r) : {RCV_CTX_N{1'b0}};
	assign rcv_sw_clr = (reg_wr && hit_rev_clr) ? wr_r : {RCV_CTX_N{1'b0}};
	assign rcv_event_nxt = (rcv_event_r & ~rcv_sw_clr) | rcv_hw_set | rcv_sw_set;

	// Fairness limit is a plain read/write field
	assign fair_limit_nxt = (reg_wr && hit_fair) ? reg_wdata[FAIR_W-1:0] : fair_limit_r;

	// ----------------------------------------
	// Link control bits
	// ----------------------------------------
	// One write hits one address; set and clear never meet
	function automatic logic set_clr_bit(input logic cur, input logic s, input logic c);
		set_clr_bit = c ? 1'b0 : (s ? 1'b1 : cur);
	endfunction

	// Strobes for the link pair
	logic link_s;
	logic link_c;
	logic overlong_hit;
	assign link_s = reg_wr && hit_link_set;
	assign link_c = reg_wr && hit_link_clr;

	assign timer_en_nxt = set_clr_bit(timer_en_r, link_s && reg_wdata[LINK_TIMER_EN_BIT],
		link_c && reg_wdata[LINK_TIMER_EN_BIT]);
	assign rx_phy_en_nxt = set_clr_bit(rx_phy_en_r, link_s && reg_wdata[LINK_RX_PHY_BIT],
		link_c && reg_wdata[LINK_RX_PHY_BIT]);
	assign self_id_accept_nxt = set_clr_bit(self_id_accept_r, link_s && reg_wdata[LINK_SELF_ID_BIT],
		link_c && reg_wdata[LINK_SELF_ID_BIT]);

	// Overlong cycle forces master off and blocks any set while the event stands
	assign cycle_master_nxt = (overlong_hit || overlong_r) ? 1'b0
		: set_clr_bit(cycle_master_r, link_s && reg_wdata[LINK_CYCLE_MASTER_BIT],
		link_c && reg_wdata[LINK_CYCLE_MASTER_BIT]);

	// ----------------------------------------
	// Overlong cycle watchdog
	// ----------------------------------------
	// Counts from start of a sent cycle start to the next subaction gap end
	logic [15:0] overlong_cnt_r;
	logic overlong_run_r;
	assign overlong_hit = overlong_run_r && !subaction_gap_end
		&& (overlong_cnt_r == 16'(OVERLONG_LIMIT));
	// Hardware set wins over the clear strobe
	assign overlong_nxt = overlong_hit | (overlong_r & ~cycle_too_long_clear);

	// Run drops at the hit: one long cycle, one event
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			overlong_cnt_r <= 16'h0000;
			overlong_run_r <= 1'b0;
		end else if (cycle_start_tx_begin) begin
			overlong_cnt_r <= 16'h0001;
			overlong_run_r <= 1'b1;
		end else if (subaction_gap_end || overlong_hit) begin
			overlong_run_r <= 1'b0;
		end else if (overlong_run_r) begin
			overlong_cnt_r <= overlong_cnt_r + 16'h0001;
		end
	end

	// ----------------------------------------
	// Register update
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			xmit_mask_r <= XMIT_MASK_RST;
			rcv_mask_r <= RCV_MASK_RST;
			rcv_event_r <= RCV_EVENT_RST;
			fair_limit_r <= FAIR_RST;
			cycle_master_r <= LINK_RST[LINK_CYCLE_MASTER_BIT];
			timer_en_r <= LINK_RST[LINK_TIMER_EN_BIT];
			rx_phy_en_r <= LINK_RST[LINK_RX_PHY_BIT];
			self_id_accept_r <= LINK_RST[LINK_SELF_ID_BIT];
			overlong_r <= 1'b0;
		end else begin
			xmit_mask_r <= xmit_mask_nxt;
			rcv_mask_r <= rcv_mask_nxt;
			rcv_event_r <= rcv_event_nxt;
			fair_limit_r <= fair_limit_nxt;
			cycle_master_r <= cycle_master_nxt;
			timer_en_r <= timer_en_nxt;
			rx_phy_en_r <= rx_phy_en_nxt;
			self_id_accept_r <= self_id_accept_nxt;
			overlong_r <= overlong_nxt;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Set and clear addresses read the same value; unmapped and reserved bits read zero
	logic [DATA_W-1:0] link_word;
	logic [DATA_W-1:0] rd_word;
	always_comb begin
		link_word = '0;
		link_word[LINK_CYCLE_MASTER_BIT] = cycle_master_r;
		link_word[LINK_TIMER_EN_BIT] = timer_en_r;
		link_word[LINK_RX_PHY_BIT] = rx_phy_en_r;
		link_word[LINK_SELF_ID_BIT] = self_id_accept_r;
	end

	assign rd_word = (hit_xmask_set || hit_xmask_clr) ? {24'h000000, xmit_mask_r}
		: (hit_rev_set || hit_rev_clr) ? {28'h0000000, rcv_event_r}
		: (hit_rmask_set || hit_rmask_clr) ? {28'h0000000, rcv_mask_r}
		: hit_fair ? {24'h000000, fair_limit_r}
		: (hit_link_set || hit_link_clr) ? link_word : 32'h0000_0000;

	// Read data stands only in the cycle after the strobe
	// Zero outside the slot, so banks may share a bus
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= (reg_rd && hit_any) ? rd_word : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Completion summaries
	// ----------------------------------------
	// Receive summary tracks the event register's next value
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			iso_xmit_irq_gated <= 8'h00;
			iso_xmit_dma_complete <= 1'b0;
			iso_rcv_dma_complete <= 1'b0;
		end else begin
			iso_xmit_irq_gated <= iso_xmit_ctx_irq & xmit_mask_r;
			iso_xmit_dma_complete <= |(iso_xmit_ctx_irq & xmit_mask_r);
			iso_rcv_dma_complete <= |(rcv_event_nxt & rcv_mask_nxt);
		end
	end

	// ----------------------------------------
	// Fairness budget
	// ----------------------------------------
	// Counter saturates so a burst cannot wrap back under the limit
	// Limit zero blocks all requests until software sets one
	logic [FAIR_W-1:0] fair_cnt_r;
	logic [FAIR_W-1:0] fair_cnt_nxt;
	assign fair_cnt_nxt = fairness_interval_start ? 8'h00
		: (request_pkt_sent && fair_cnt_r != 8'hFF) ? fair_cnt_r + 8'h01 : fair_cnt_r;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fair_cnt_r <= 8'h00;
			request_tx_allowed <= 1'b0;
		end else begin
			fair_cnt_r <= fair_cnt_nxt;
			request_tx_allowed <= (fair_cnt_nxt < fair_limit_nxt);
		end
	end

	// ----------------------------------------
	// Cycle timer and cycle start control
	// ----------------------------------------
	// Offset reaches the port one cycle late
	logic [11:0] offset_w;
	logic rollover_w;

	cycle_offset_timer u_cycle_timer (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.enable(timer_en_r),
		.offset(offset_w),
		.rollover(rollover_w)
	);

	// Cycle start uses the registered master bit
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cycle_offset <= 12'h000;
			accept_rx_cycle_start <= 1'b1;
			cycle_start_generate <= 1'b0;
			cycle_too_long_event <= 1'b0;
		end else begin
			cycle_offset <= offset_w;
			accept_rx_cycle_start <= !cycle_master_nxt;
			cycle_start_generate <= rollover_w && cycle_master_r && phy_is_root;
			cycle_too_long_event <= overlong_nxt;
		end
	end

	// ----------------------------------------
	// Receive routing
	// ----------------------------------------
	// Self-ID packets follow only their own bit; PHY packets need the bit and an enabled context
	logic phy_ok;
	logic sid_ok;
	assign phy_ok = rx_pkt.valid && rx_pkt.is_phy && !rx_pkt.is_self_id && !self_id_phase
		&& rx_phy_en_r && async_receive_req_enabled;
	assign sid_ok = rx_pkt.valid && rx_pkt.is_self_id && self_id_accept_r;

	// Registered: each decision is a pulse after the packet
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_route <= '0;
		end else begin
			rx_route.phy_to_async_receive <= phy_ok;
			rx_route.self_id_accept <= sid_ok;
			rx_route.discard <= rx_pkt.valid && (rx_pkt.is_phy || rx_pkt.is_self_id)
				&& !phy_ok && !sid_ok;
		end
	end

endmodule
`default_nettype wire

// ---- verif/iso_link_regs_sva.sv ----
// Port-level checker for the isochronous interrupt and link control register bank
`default_nettype none
module iso_link_regs_sva
	import iso_link_regs_pkg::*;
#(
	parameter int OVERLONG_LIMIT = OVERLONG_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic [XMIT_CTX_N-1:0] iso_xmit_ctx_irq,
	input wire logic [XMIT_CTX_N-1:0] iso_xmit_irq_gated,
	input wire logic iso_xmit_dma_complete,
	input wire logic phy_is_root,
	input wire logic cycle_start_tx_begin,
	input wire logic subaction_gap_end,
	input wire logic cycle_too_long_event,
	input wire logic accept_rx_cycle_start,
	input wire logic cycle_start_generate,
	input wire logic [11:0] cycle_offset,
	input wire rx_pkt_type rx_pkt,
	input wire logic self_id_phase,
	input wire logic async_receive_req_enabled,
	input wire rx_route_type rx_route
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] span_r;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Cycles since a cycle start began; a gap end stops the count so no overlong is due
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			span_r <= 16'h0000;
		end else if (cycle_start_tx_begin) begin
			span_r <= 16'h0001;
		end else if (subaction_gap_end) begin
			span_r <= 16'h0000;
		end else if (span_r != 16'h0000) begin
			span_r <= span_r + 16'h0001;
		end
	end

	// ----------------------------------------
	// Overlong cycle steps
	// ----------------------------------------
	sequence s_overlong_hit;
		$rose(cycle_too_long_event);
	endsequence
	sequence s_master_dropped;
		##[0:2] accept_rx_cycle_start;
	endsequence

	// Assertions on the port relations
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data present outside the read slot");
	AST_XMIT_GATE: assert property ((iso_xmit_irq_gated & ~$past(iso_xmit_ctx_irq)) == 8'h00)
		else $error("transmit interrupt without a context request");
	AST_XMIT_OR: assert property (iso_xmit_dma_complete == (|iso_xmit_irq_gated))
		else $error("transmit summary differs from gated contexts");
	AST_OFFSET_STEP: assert property ($changed(cycle_offset) |->
		(cycle_offset == $past(cycle_offset) + 12'h001) || (cycle_offset == 12'h000 && $past(cycle_offset) == 12'hBFF))
		else $error("cycle offset jumped");
	AST_CYCLE_GEN: assert property (cycle_start_generate |->
		($past(phy_is_root) && !$past(accept_rx_cycle_start)) ##1 !cycle_start_generate)
		else $error("cycle start made without master and root");
	AST_OVERLONG_MASTER: assert property (s_overlong_hit |-> s_master_dropped)
		else $error("cycle master kept after overlong cycle");
	AST_OVERLONG_SPAN: assert property (s_overlong_hit |-> span_r >= OVERLONG_LIMIT && span_r <= OVERLONG_LIMIT + 3)
		else $error("overlong raised at the wrong time");
	AST_ROUTE_IDLE: assert property (!$past(rx_pkt.valid) |-> rx_route == '0)
		else $error("route pulse without a packet");
	AST_ROUTE_PHY: assert property (rx_route.phy_to_async_receive |->
		$past(rx_pkt.is_phy) && $past(async_receive_req_enabled) && !$past(self_id_phase))
		else $error("phy packet delivered when it should drop");
	AST_ROUTE_SID: assert property (rx_route.self_id_accept |-> $past(rx_pkt.valid) && $past(rx_pkt.is_self_id))
		else $error("self id accepted for another packet");
endmodule
`default_nettype wire

// ---- verif/iso_irq_mask_link_control_regs_tb_top.sv ----
// Self-checking bench for the isochronous interrupt and link control register bank
`default_nettype none
module iso_irq_mask_link_control_regs_tb_top
	import iso_link_regs_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	// Small overlong limit keeps the run short
	localparam int LIMIT = 20;
	localparam logic [4:0] P_INT = 5'h10;
	localparam logic [4:0] P_REQ = 5'h08;
	localparam logic [4:0] P_BEG = 5'h04;
	localparam logic [4:0] P_GAP = 5'h02;
	localparam logic [4:0] P_CLR = 5'h01;
	typedef struct {logic wr; logic [11:0] a; logic [31:0] d;} row_type;
	logic ref_clk, resetn, reg_wr, reg_rd, phy_is_root, self_id_phase, async_receive_req_enabled, found;
	logic iso_xmit_dma_complete, iso_rcv_dma_complete, request_tx_allowed, cycle_too_long_event;
	logic accept_rx_cycle_start, cycle_start_generate;
	logic [4:0] pls;
	logic [11:0] reg_addr, cycle_offset, o;
	logic [31:0] reg_wdata, reg_rdata;
	logic [7:0] iso_xmit_ctx_irq, iso_xmit_irq_gated;
	logic [3:0] iso_rcv_input_last_done, iso_rcv_irq_always;
	rx_pkt_type rx_pkt;
	rx_route_type rx_route;
	wire fairness_interval_start, request_pkt_sent, cycle_start_tx_begin, subaction_gap_end, cycle_too_long_clear;
	int n_errors = 0;
	int samples_checked = 0;
	// Register table rows: a write, or a read with its expected value
	row_type rows[20] = '{
		'{1'b0, 12'h098, 32'h0}, '{1'b1, 12'h098, 32'hFFFF_FFFF}, '{1'b0, 12'h098, 32'hFF}, '{1'b0, 12'h09C, 32'hFF},
		'{1'b1, 12'h09C, 32'h0F}, '{1'b0, 12'h098, 32'hF0}, '{1'b1, 12'h0A8, 32'hFFFF_FFF5}, '{1'b0, 12'h0AC, 32'h5},
		'{1'b1, 12'h0A0, 32'hF}, '{1'b0, 12'h0A4, 32'h5}, '{1'b1, 12'h0A4, 32'h1}, '{1'b0, 12'h0A0, 32'h4},
		'{1'b1, 12'h0DC, 32'hFFFF_FF03}, '{1'b0, 12'h0DC, 32'h3}, '{1'b1, 12'h0E0, 32'hFFFF_FFFF},
		'{1'b0, 12'h0E4, 32'h0030_0600}, '{1'b1, 12'h0E4, 32'h0020_0000}, '{1'b0, 12'h0E0, 32'h0010_0600},
		'{1'b1, 12'h0F0, 32'hFFFF_FFFF}, '{1'b0, 12'h0F0, 32'h0}};

	// Event pulses share one driven vector
	assign {fairness_interval_start, request_pkt_sent, cycle_start_tx_begin, subaction_gap_end, cycle_too_long_clear} = pls;

	iso_irq_mask_link_control_regs #(.OVERLONG_LIMIT(LIMIT)) i_iso_irq_mask_link_control_regs (
		.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .iso_xmit_ctx_irq,
		.iso_rcv_input_last_done, .iso_rcv_irq_always, .iso_xmit_irq_gated, .iso_xmit_dma_complete,
		.iso_rcv_dma_complete, .fairness_interval_start, .request_pkt_sent, .request_tx_allowed, .phy_is_root,
		.cycle_start_tx_begin, .subaction_gap_end, .cycle_too_long_clear, .cycle_too_long_event,
		.accept_rx_cycle_start, .cycle_start_generate, .cycle_offset, .rx_pkt, .self_id_phase,
		.async_receive_req_enabled, .rx_route);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so look there
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge ref_clk);
		pls <= m;
		@(posedge ref_clk);
		pls <= 5'h00;
	endtask
	task automatic send(input logic p, input logic s, input logic [2:0] e);
		@(posedge ref_clk);
		rx_pkt <= '{1'b1, p, s};
		@(posedge ref_clk);
		rx_pkt <= '0;
		#1;
		chk(rx_route, e);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Watchdog: the longest wait is one 6250-cycle timer lap, so this leaves ample margin
	initial begin
		tick(20000);
		n_errors++;
		print_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata, pls, iso_xmit_ctx_irq, iso_rcv_input_last_done} = '0;
		{iso_rcv_irq_always, phy_is_root, self_id_phase, async_receive_req_enabled, rx_pkt} = '0;
		tick(6);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].a, rows[i].d);
			end else begin
				rd(rows[i].a, rows[i].d);
			end
		end
		$display("done: register table");
		@(posedge ref_clk);
		iso_xmit_ctx_irq <= 8'hFF;
		tick(2);
		#1;
		chk(iso_xmit_irq_gated, 8'hF0);
		chk(iso_xmit_dma_complete, 1'b1);
		@(posedge ref_clk);
		iso_xmit_ctx_irq <= 8'h0F;
		tick(2);
		#1;
		chk({iso_xmit_irq_gated, iso_xmit_dma_complete}, 9'h000);
		$display("done: transmit mask");
		// Receive completions against mask 5
		wr(12'h0A4, 32'hF);
		@(posedge ref_clk);
		iso_rcv_input_last_done <= 4'hF;
		iso_rcv_irq_always <= 4'hF;
		@(posedge ref_clk);
		iso_rcv_input_last_done <= 4'h0;
		#1;
		chk(iso_rcv_dma_complete, 1'b1);
		rd(12'h0A0, 32'h5);
		wr(12'h0A4, 32'h4);
		rd(12'h0A0, 32'h1);
		wr(12'h0A4, 32'h1);
		@(posedge ref_clk);
		iso_rcv_input_last_done <= 4'hF;
		iso_rcv_irq_always <= 4'h0;
		@(posedge ref_clk);
		iso_rcv_input_last_done <= 4'h0;
		#1;
		chk(iso_rcv_dma_complete, 1'b0);
		rd(12'h0A0, 32'h0);
		$display("done: receive events");
		// Fairness limit of three requests per interval
		pulse(P_INT);
		#1;
		chk(request_tx_allowed, 1'b1);
		repeat (3) pulse(P_REQ);
		#1;
		chk(request_tx_allowed, 1'b0);
		pulse(P_INT);
		#1;
		chk(request_tx_allowed, 1'b1);
		wr(12'h0DC, 32'h0);
		#1;
		chk(request_tx_allowed, 1'b0);
		$display("done: fairness");
		// Offset advances 0.49152 per clock while enabled
		o = cycle_offset;
		tick(100);
		#1;
		chk((cycle_offset - o) inside {12'h031, 12'h032}, 1'b1);
		wr(12'h0E4, 32'h0010_0000);
		tick(2);
		#1;
		o = cycle_offset;
		tick(50);
		#1;
		chk(cycle_offset, o);
		chk(accept_rx_cycle_start, 1'b1);
		@(posedge ref_clk);
		phy_is_root <= 1'b1;
		wr(12'h0E0, 32'h0030_0000);
		found = 1'b0;
		for (int i = 0; i < 6400 && !found; i++) begin
			@(posedge ref_clk);
			#1 found = cycle_start_generate;
		end
		chk(found, 1'b1);
		chk(cycle_offset < 12'h003, 1'b1);
		chk(accept_rx_cycle_start, 1'b0);
		$display("done: cycle timer");
		pulse(P_BEG);
		tick(5);
		pulse(P_GAP);
		tick(LIMIT + 10);
		#1;
		chk(cycle_too_long_event, 1'b0);
		pulse(P_BEG);
		tick(LIMIT + 5);
		#1;
		chk({cycle_too_long_event, accept_rx_cycle_start}, 2'b11);
		wr(12'h0E0, 32'h0020_0000);
		rd(12'h0E0, 32'h0010_0600);
		pulse(P_CLR);
		tick(1);
		#1;
		chk(cycle_too_long_event, 1'b0);
		wr(12'h0E0, 32'h0020_0000);
		rd(12'h0E0, 32'h0030_0600);
		$display("done: overlong");
		// Every setting of the two receive bits, with both packet kinds
		@(posedge ref_clk);
		async_receive_req_enabled <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(12'h0E4, 32'h0000_0600);
			wr(12'h0E0, {21'h0, k[0], k[1], 9'h0});
			send(1'b1, 1'b0, {k[0], 1'b0, ~k[0]});
			send(1'b0, 1'b1, {1'b0, k[1], ~k[1]});
		end
		@(posedge ref_clk);
		self_id_phase <= 1'b1;
		send(1'b1, 1'b0, 3'b001);
		send(1'b0, 1'b1, 3'b010);
		@(posedge ref_clk);
		self_id_phase <= 1'b0;
		async_receive_req_enabled <= 1'b0;
		send(1'b1, 1'b0, 3'b001);
		$display("done: packet routing");
		@(posedge ref_clk);
		resetn <= 1'b0;
		tick(2);
		#1;
		chk(accept_rx_cycle_start, 1'b1);
		chk(cycle_offset, 12'h000);
		@(posedge ref_clk);
		resetn <= 1'b1;
		rd(12'h0E0, 32'h0);
		rd(12'h0DC, 32'h0);
		rd(12'h098, 32'h0);
		$display("done: second reset");
		print_verdict();
	end
endmodule

bind iso_irq_mask_link_control_regs iso_link_regs_sva #(.OVERLONG_LIMIT(OVERLONG_LIMIT)) i_iso_link_regs_sva (
	.ref_clk, .resetn, .reg_rd, .reg_rdata, .iso_xmit_ctx_irq, .iso_xmit_irq_gated, .iso_xmit_dma_complete,
	.phy_is_root, .cycle_start_tx_begin, .subaction_gap_end, .cycle_too_long_event, .accept_rx_cycle_start,
	.cycle_start_generate, .cycle_offset, .rx_pkt, .self_id_phase, .async_receive_req_enabled, .rx_route);
`default_nettype wire
